// ---- rtl/ipr_pkg.sv ----
// Constants shared by the interrupt priority register bank
package ipr_pkg;

  // Register bus
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 3;
  localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;

  // Register indices on the register port
  localparam int unsigned REG_CCP3 = 0;
  localparam int unsigned REG_SER2 = 1;
  localparam int unsigned REG_CCP5 = 2;
  localparam int unsigned REG_SYNC2 = 3;
  localparam int unsigned REG_CAL = 4;
  localparam int unsigned REG_SERERR = 5;
  localparam int unsigned NUM_REGS = 6;

  // Priority field width and codes
  localparam int unsigned PRIO_W = 3;
  localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_LOW = 3'h1;
  localparam logic [PRIO_W-1:0] PRIO_TOP = 3'h7;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;

  // Field positions inside a register
  localparam int unsigned LSB_HIGH = 12;
  localparam int unsigned LSB_MID = 8;
  localparam int unsigned LSB_LOW = 4;
  localparam int unsigned LSB_BASE = 0;

  // Source numbering
  localparam int unsigned NUM_SRC = 11;
  localparam int unsigned SRC_W = 4;
  localparam int unsigned SRC_CCP3_TIMER = 0;
  localparam int unsigned SRC_SERIAL2_TX = 1;
  localparam int unsigned SRC_SERIAL2_RX = 2;
  localparam int unsigned SRC_EXT_IRQ2 = 3;
  localparam int unsigned SRC_CCP4_TIMER = 4;
  localparam int unsigned SRC_CCP5_TIMER = 5;
  localparam int unsigned SRC_SYNC2_COLLISION = 6;
  localparam int unsigned SRC_SYNC2_EVENT = 7;
  localparam int unsigned SRC_CALENDAR = 8;
  localparam int unsigned SRC_SERIAL2_ERROR = 9;
  localparam int unsigned SRC_SERIAL1_ERROR = 10;

  // Register holding each source, by source number
  localparam int unsigned SRC_REG [NUM_SRC] = '{
    REG_CCP3, REG_SER2, REG_SER2, REG_SER2, REG_SER2, REG_CCP5,
    REG_SYNC2, REG_SYNC2, REG_CAL, REG_SERERR, REG_SERERR};

  // Field lsb of each source, by source number
  localparam int unsigned SRC_LSB [NUM_SRC] = '{
    LSB_HIGH, LSB_HIGH, LSB_MID, LSB_LOW, LSB_BASE, LSB_LOW,
    LSB_MID, LSB_LOW, LSB_MID, LSB_MID, LSB_LOW};

endpackage

// ---- rtl/ipr_arbiter.sv ----
// Picks the highest-priority pending enabled source
`timescale 1ns/1ps
module ipr_arbiter #(
  parameter int unsigned NUM_SRC = ipr_pkg::NUM_SRC,
  parameter int unsigned SRC_W = ipr_pkg::SRC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sources
  input wire logic [NUM_SRC-1:0] pending,
  input wire logic [NUM_SRC-1:0][ipr_pkg::PRIO_W-1:0] prio,
  // Winner
  output logic req_q,
  output logic [ipr_pkg::PRIO_W-1:0] level_q,
  output logic [SRC_W-1:0] source_q
);

  typedef struct packed {
    logic req;
    logic [ipr_pkg::PRIO_W-1:0] level;
    logic [SRC_W-1:0] source;
  } ipr_arb_s;

  ipr_arb_s cur_q;
  ipr_arb_s nxt_d;

  // Strictly greater wins, so ties go to the lower source number
  always_comb begin
    nxt_d = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (pending[i] && prio[i] != ipr_pkg::PRIO_OFF && prio[i] > nxt_d.level) begin
        nxt_d.req = 1'b1;
        nxt_d.level = prio[i];
        nxt_d.source = SRC_W'(i);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign req_q = cur_q.req;
  assign level_q = cur_q.level;
  assign source_q = cur_q.source;

endmodule // ipr_arbiter

// ---- rtl/ipr_regs.sv ----
// Interrupt priority register bank with source arbitration
// What this block does
// - Field code 111 means priority level 7, the highest.
// - Field code 000 disables the source; it never requests service.
// - Field code 001 means priority level 1, lowest active level.
// - Unimplemented bits read zero and ignore writes.
// - Each field resets to top bit one, lower bits zero: level 4.
// - Every implemented field bit is readable and writable by software.
// - Timer 3 register: priority in bits 14:12, rest unimplemented.
// - Serial port 2 register: transmit bits 14:12, receive bits 10:8.
// - Same register: external irq 2 bits 6:4, timer 4 bits 2:0.
// - Timer 5 register: priority in bits 6:4, rest unimplemented.
// - Sync serial 2 register: collision bits 10:8, event bits 6:4.
// - Calendar register: priority in bits 10:8, rest read zero.
// - Error register: port 2 error bits 10:8, port 1 bits 6:4.
// - After any reset every source sits at priority level 4.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module ipr_regs #(
  parameter int unsigned ADDR_W = ipr_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Register port
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [ipr_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [ipr_pkg::DATA_W-1:0] REG_RDATA,
  // Pending sources
  input wire logic [ipr_pkg::NUM_SRC-1:0] SRC_PENDING,
  // Field values
  output logic [ipr_pkg::PRIO_W-1:0] CCP3_TIMER_PRIO,
  output logic [ipr_pkg::PRIO_W-1:0] SERIAL2_TX_PRIO,
  output logic [ipr_pkg::PRIO_W-1:0] SERIAL2_RX_PRIO,
  output logic [ipr_pkg::PRIO_W-1:0] EXT_IRQ2_PRIO,
  output logic [ipr_pkg::PRIO_W-1:0] CCP4_TIMER_PRIO,
  output logic [ipr_pkg::PRIO_W-1:0] CCP5_TIMER_PRIO,
  output logic [ipr_pkg::PRIO_W-1:0] SYNC2_COLLISION_PRIO,
  output logic [ipr_pkg::PRIO_W-1:0] SYNC2_EVENT_PRIO,
  output logic [ipr_pkg::PRIO_W-1:0] CALENDAR_PRIO,
  output logic [ipr_pkg::PRIO_W-1:0] SERIAL2_ERROR_PRIO,
  output logic [ipr_pkg::PRIO_W-1:0] SERIAL1_ERROR_PRIO,
  // Source enabled flags
  output logic [ipr_pkg::NUM_SRC-1:0] SRC_ENABLED,
  // Arbitration result
  output logic IRQ_REQUEST,
  output logic [ipr_pkg::PRIO_W-1:0] IRQ_LEVEL,
  output logic [ipr_pkg::SRC_W-1:0] IRQ_SOURCE
);

  typedef logic [ipr_pkg::NUM_SRC-1:0][ipr_pkg::PRIO_W-1:0] ipr_prio_t;

  typedef struct packed {
    ipr_prio_t prio;
    logic [ipr_pkg::NUM_SRC-1:0] enabled;
    logic [ipr_pkg::DATA_W-1:0] rdata;
  } ipr_regs_s;

  ipr_regs_s cur_q;
  ipr_regs_s nxt_d;

  // Address decode for one register index
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input int unsigned idx);
    return addr == ADDR_W'(idx);
  endfunction

  // Assembles a register word; bits with no field stay zero
  function automatic logic [ipr_pkg::DATA_W-1:0] read_word(input logic [ADDR_W-1:0] addr,
                                                            input ipr_prio_t prio);
    logic [ipr_pkg::DATA_W-1:0] w;
    w = ipr_pkg::READ_IDLE;
    for (int i = 0; i < ipr_pkg::NUM_SRC; i++) begin
      if (addr_hit(addr, ipr_pkg::SRC_REG[i])) begin
        w[ipr_pkg::SRC_LSB[i] +: ipr_pkg::PRIO_W] = prio[i];
      end
    end
    return w;
  endfunction

  // Field writes, enable flags and read data
  always_comb begin
    nxt_d = cur_q;
    for (int i = 0; i < ipr_pkg::NUM_SRC; i++) begin
      // Only the field bits are taken; other write bits are dropped
      if (REG_WR && addr_hit(REG_ADDR, ipr_pkg::SRC_REG[i])) begin
        nxt_d.prio[i] = REG_WDATA[ipr_pkg::SRC_LSB[i] +: ipr_pkg::PRIO_W];
      end
      nxt_d.enabled[i] = nxt_d.prio[i] != ipr_pkg::PRIO_OFF;
    end
    // Read data stand one cycle, zero otherwise and for unmapped indices
    nxt_d.rdata = REG_RD ? read_word(REG_ADDR, cur_q.prio) : ipr_pkg::READ_IDLE;
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      cur_q.prio <= {ipr_pkg::NUM_SRC{ipr_pkg::PRIO_RESET}};
      cur_q.enabled <= {ipr_pkg::NUM_SRC{1'b1}};
      cur_q.rdata <= ipr_pkg::READ_IDLE;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // Arbitration over the stored fields
  ipr_arbiter #(
    .NUM_SRC(ipr_pkg::NUM_SRC),
    .SRC_W(ipr_pkg::SRC_W)
  ) u_arbiter (
    .clk(CLK_SYS),
    .reset(RESET),
    .pending(SRC_PENDING),
    .prio(cur_q.prio),
    .req_q(IRQ_REQUEST),
    .level_q(IRQ_LEVEL),
    .source_q(IRQ_SOURCE)
  );

  // Register outputs
  assign REG_RDATA = cur_q.rdata;
  assign SRC_ENABLED = cur_q.enabled;
  assign CCP3_TIMER_PRIO = cur_q.prio[ipr_pkg::SRC_CCP3_TIMER];
  assign SERIAL2_TX_PRIO = cur_q.prio[ipr_pkg::SRC_SERIAL2_TX];
  assign SERIAL2_RX_PRIO = cur_q.prio[ipr_pkg::SRC_SERIAL2_RX];
  assign EXT_IRQ2_PRIO = cur_q.prio[ipr_pkg::SRC_EXT_IRQ2];
  assign CCP4_TIMER_PRIO = cur_q.prio[ipr_pkg::SRC_CCP4_TIMER];
  assign CCP5_TIMER_PRIO = cur_q.prio[ipr_pkg::SRC_CCP5_TIMER];
  assign SYNC2_COLLISION_PRIO = cur_q.prio[ipr_pkg::SRC_SYNC2_COLLISION];
  assign SYNC2_EVENT_PRIO = cur_q.prio[ipr_pkg::SRC_SYNC2_EVENT];
  assign CALENDAR_PRIO = cur_q.prio[ipr_pkg::SRC_CALENDAR];
  assign SERIAL2_ERROR_PRIO = cur_q.prio[ipr_pkg::SRC_SERIAL2_ERROR];
  assign SERIAL1_ERROR_PRIO = cur_q.prio[ipr_pkg::SRC_SERIAL1_ERROR];

endmodule // ipr_regs

// ---- testbench/ipr_regs_assertions.sv ----
// Property checker for the priority register bank
`timescale 1ns/1ps
module ipr_regs_chk (
  // Clock, reset, register port
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [2:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  // Sources and results
  input wire logic [10:0] SRC_PENDING,
  input wire logic [2:0] SERIAL2_TX_PRIO,
  input wire logic [2:0] CCP4_TIMER_PRIO,
  input wire logic [10:0] SRC_ENABLED,
  input wire logic IRQ_REQUEST,
  input wire logic [2:0] IRQ_LEVEL
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  sequence s_wr1; REG_WR && REG_ADDR == 3'h1; endsequence
  sequence s_rd1; REG_RD && REG_ADDR == 3'h1; endsequence
  property p_idle_zero; !REG_RD |=> REG_RDATA == 16'h0000; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data not idle");
  property p_unimpl; REG_RD |=> (REG_RDATA & 16'h8888) == 16'h0000; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused bit read high");
  property p_ser2_wr; s_wr1 |=> SERIAL2_TX_PRIO == $past(REG_WDATA[14:12]) && CCP4_TIMER_PRIO == $past(REG_WDATA[2:0]);
  endproperty
  a_ser2_wr: assert property (p_ser2_wr) else $error("field write lost");
  property p_readback; s_wr1 ##1 s_rd1 |=> REG_RDATA == ($past(REG_WDATA, 2) & 16'h7777); endproperty
  a_readback: assert property (p_readback) else $error("readback wrong");
  property p_no_req; IRQ_REQUEST |-> $past(|(SRC_PENDING & SRC_ENABLED)); endproperty
  a_no_req: assert property (p_no_req) else $error("request from disabled source");
  property p_top; $past(SRC_PENDING[1]) && $past(SERIAL2_TX_PRIO) == 3'h7 |-> IRQ_REQUEST && IRQ_LEVEL == 3'h7;
  endproperty
  a_top: assert property (p_top) else $error("top level not granted");
  property p_ccp3; REG_WR && REG_ADDR == 3'h0 |=> SRC_ENABLED[0] == ($past(REG_WDATA[14:12]) != 3'h0); endproperty
  a_ccp3: assert property (p_ccp3) else $error("timer 3 field misplaced");
  property p_reset; $fell(RESET) |-> SERIAL2_TX_PRIO == 3'h4 && CCP4_TIMER_PRIO == 3'h4; endproperty
  a_reset: assert property (p_reset) else $error("field reset value wrong");
endmodule // ipr_regs_chk

// ---- testbench/ipr_regs_tb.sv ----
// Self-checking bench for the priority register bank
`timescale 1ns/1ps
module ipr_regs_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [10:0] src_pending = 11'h000;
  logic [15:0] reg_rdata;
  logic irq_request;
  logic [2:0] irq_level;
  logic [3:0] irq_source;
  logic rd_d = 1'b0;
  logic [2:0] rd_a = 3'h0;
  logic arb_chk = 1'b0;
  logic [15:0] exp_irq[$];
  logic [2:0] ccp3_p, tx_p, rx_p, ext_p, ccp4_p, ccp5_p, coll_p, evt_p, cal_p, err2_p, err1_p;
  logic [10:0] src_enabled;
  logic [15:0] exp_q[$];
  logic [15:0] model [8];
  int n_fail = 0;
  int samples_checked = 0;
  localparam logic [15:0] MASK [8] = '{16'h7000, 16'h7777, 16'h0070, 16'h0770, 16'h0700, 16'h0770, 16'h0000, 16'h0000};
  always #20 clk_sys = ~clk_sys;
  ipr_regs i_dut (.CLK_SYS(clk_sys), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SRC_PENDING(src_pending),
    .CCP3_TIMER_PRIO(ccp3_p), .SERIAL2_TX_PRIO(tx_p), .SERIAL2_RX_PRIO(rx_p), .EXT_IRQ2_PRIO(ext_p),
    .CCP4_TIMER_PRIO(ccp4_p), .CCP5_TIMER_PRIO(ccp5_p), .SYNC2_COLLISION_PRIO(coll_p),
    .SYNC2_EVENT_PRIO(evt_p), .CALENDAR_PRIO(cal_p), .SERIAL2_ERROR_PRIO(err2_p),
    .SERIAL1_ERROR_PRIO(err1_p), .SRC_ENABLED(src_enabled),
    .IRQ_REQUEST(irq_request), .IRQ_LEVEL(irq_level), .IRQ_SOURCE(irq_source));
  task check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    model[a] = d & MASK[a];
  endtask
  task rd(input logic [2:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    exp_q.push_back(model[a]);
  endtask
  task idle(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
  endtask
  task reset_dut;
    reset <= 1'b1;
    foreach (model[i]) model[i] = MASK[i] & 16'h4444;
    idle(8);
    reset <= 1'b0;
  endtask
  task read_all;
    for (int i = 0; i < 8; i++) rd(i[2:0]);
    idle(2);
  endtask
  task complete_run;
    $display("checked %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Register word rebuilt from the field outputs
  function automatic logic [15:0] field_word(input logic [2:0] a);
    case (a)
      3'h0: return {1'b0, ccp3_p, 12'h000};
      3'h1: return {1'b0, tx_p, 1'b0, rx_p, 1'b0, ext_p, 1'b0, ccp4_p};
      3'h2: return {9'h000, ccp5_p, 4'h0};
      3'h3: return {5'h00, coll_p, 1'b0, evt_p, 4'h0};
      3'h4: return {5'h00, cal_p, 8'h00};
      3'h5: return {5'h00, err2_p, 1'b0, err1_p, 4'h0};
      default: return 16'h0000;
    endcase
  endfunction
  // Enabled flags expected from the model, source order
  function automatic logic [15:0] en_want();
    return {5'h00, model[5][6:4] != 3'h0, model[5][10:8] != 3'h0, model[4][10:8] != 3'h0,
      model[3][6:4] != 3'h0, model[3][10:8] != 3'h0, model[2][6:4] != 3'h0, model[1][2:0] != 3'h0,
      model[1][6:4] != 3'h0, model[1][10:8] != 3'h0, model[1][14:12] != 3'h0, model[0][14:12] != 3'h0};
  endfunction
  // Strobes taken at the rising edge
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    rd_a <= reg_addr;
  end
  // Result monitor, away from the launching edge
  always @(negedge clk_sys) begin
    logic [15:0] want;
    if (rd_d) begin
      want = exp_q.pop_front();
      check(reg_rdata, want);
      check(field_word(rd_a), want);
    end
    if (arb_chk) begin
      check({8'h00, irq_request, irq_level, irq_source}, exp_irq.pop_front());
      check({5'h00, src_enabled}, en_want());
    end
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    complete_run;
  end
  initial begin
    logic [2:0] a;
    a = 3'($urandom(32'ha02a31c2));
    reset_dut;
    read_all;
    $display("test reset values done");
    for (int c = 0; c < 8; c++) begin
      wr(3'h1, {4{1'b1, c[2:0]}});
      rd(3'h1);
    end
    for (int i = 0; i < 6; i++) wr(i[2:0], 16'h0000);
    src_pending <= 11'h7ff;
    for (int c = 0; c < 8; c++) begin
      wr(3'h1, {1'b0, c[2:0], 12'h000});
      idle(2);
      exp_irq.push_back({8'h00, c != 0, c[2:0], (c != 0) ? 4'h1 : 4'h0});
      arb_chk <= 1'b1;
      idle(1);
      arb_chk <= 1'b0;
    end
    $display("test codes and arbitration done");
    repeat (40) begin
      a = 3'($urandom_range(7));
      wr(a, 16'($urandom));
      src_pending <= 11'($urandom);
      rd(a);
      rd(3'($urandom_range(7)));
    end
    idle(2);
    reset_dut;
    read_all;
    $display("test random and second reset done");
    complete_run;
  end
endmodule // ipr_regs_tb
bind ipr_regs ipr_regs_chk i_chk (.CLK_SYS, .RESET, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
  .SRC_PENDING, .SERIAL2_TX_PRIO, .CCP4_TIMER_PRIO, .SRC_ENABLED, .IRQ_REQUEST, .IRQ_LEVEL);
